// ==== rtl/qfr_pkg.sv ====
/*
  qfr_pkg: constants and types of the quad i/o fast read sequencer.
  assumes: included by compile order ahead of every other qfr file.
*/
package qfr_pkg;

  // ----------------------------------------------------------------
  // serial command set
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_QUAD_READ      = 8'hEB;
  localparam logic [7:0] OP_QUAD_READ_WIDE = 8'hEC;
  localparam logic [3:0] MODE_CONT_NIBBLE  = 4'hA;
  localparam logic [3:0] CMD_CLKS          = 4'h8;
  localparam logic [3:0] MODE_CLKS         = 4'h2;
  localparam logic [3:0] NARROW_NIBBLES    = 4'h6;
  localparam logic [3:0] WIDE_NIBBLES      = 4'h8;

  // ----------------------------------------------------------------
  // register map (axi4-lite byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_ADDR   = 8'h08;

  localparam int unsigned CTRL_EXT_BIT    = 32'h0;
  localparam int unsigned CTRL_DUMMY_LSB  = 32'h4;
  localparam int unsigned CTRL_SEED_LSB   = 32'h8;
  localparam int unsigned STAT_CONT_BIT   = 32'h0;
  localparam int unsigned STAT_WIDE_BIT   = 32'h1;
  localparam int unsigned STAT_BUSY_BIT   = 32'h2;
  localparam int unsigned STAT_ACTIVE_BIT = 32'h3;

  localparam logic       CTRL_EXT_RST  = 1'h0;
  localparam logic [3:0] DUMMY_RST     = 4'h6;
  localparam logic [7:0] CTRL_SEED_RST = 8'h00;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // crossing word widths: cfg {seed, dummy, ext}, status {cont, wide, addr}
  localparam int unsigned CFG_W  = 32'hD;
  localparam int unsigned STAT_W = 32'h22;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    LK_IDLE, LK_CMD, LK_ADDR, LK_MODE, LK_DUMMY, LK_DATA, LK_IGNORE
  } qfr_link_state_t;

  typedef enum logic [1:0] {SEL_CTRL, SEL_STATUS, SEL_ADDR, SEL_NONE} qfr_reg_sel_t;

endpackage

// ==== rtl/qfr_xing_if.sv ====
/*
  qfr_xing_if: one word crossing between two clock domains.
  assumes: load and src_data belong to the source clock, dst_* to the destination clock.
*/
`timescale 1ns/1ns
`default_nettype none
interface qfr_xing_if #(parameter int unsigned W = 8);
  logic         load;
  logic [W-1:0] src_data;
  logic         busy;
  logic         dst_valid;
  logic [W-1:0] dst_data;

  modport user (output load, output src_data, input busy, input dst_valid, input dst_data);
  modport xing (input load, input src_data, output busy, output dst_valid, output dst_data);
endinterface
`default_nettype wire

// ==== rtl/qfr_xing.sv ====
/*
  qfr_xing: toggle request / acknowledge handshake carrying one word across clocks.
  assumes: both resets synchronous to their own clocks; a load while busy is dropped.
*/
`timescale 1ns/1ns
`default_nettype none
module qfr_xing #(
  parameter int unsigned W       = 8,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // source domain
  input wire logic src_clk,
  input wire logic src_rst_n,
  // destination domain
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  // carried word
  qfr_xing_if.xing x
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic         req;
    logic         ack_s1;
    logic         ack_s2;
    logic [W-1:0] data;
  } qfr_src_t;

  typedef struct packed {
    logic         req_s1;
    logic         req_s2;
    logic         seen;
    logic         valid;
    logic [W-1:0] data;
  } qfr_dst_t;

  qfr_src_t src_ff, nxt_src;
  qfr_dst_t dst_ff, nxt_dst;
  logic     busy;

  // word held stable in src_ff.data until the acknowledge returns
  assign busy        = src_ff.req ^ src_ff.ack_s2;
  assign x.busy      = busy;
  assign x.dst_valid = dst_ff.valid;
  assign x.dst_data  = dst_ff.data;

  always_comb begin
    nxt_src        = src_ff;
    nxt_src.ack_s1 = dst_ff.seen;
    nxt_src.ack_s2 = src_ff.ack_s1;
    if (x.load && !busy) begin
      nxt_src.data = x.src_data;
      nxt_src.req  = ~src_ff.req;
    end
    nxt_dst        = dst_ff;
    nxt_dst.req_s1 = src_ff.req;
    nxt_dst.req_s2 = dst_ff.req_s1;
    nxt_dst.valid  = 1'b0;
    if (dst_ff.req_s2 != dst_ff.seen) begin
      nxt_dst.seen  = dst_ff.req_s2;
      nxt_dst.data  = src_ff.data;
      nxt_dst.valid = 1'b1;
    end
  end

  always_ff @(posedge src_clk) begin
    if (!src_rst_n) begin
      src_ff <= '0;
    end else begin
      src_ff <= nxt_src;
    end
  end

  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      dst_ff      <= '0;
      dst_ff.data <= RST_VAL;
    end else begin
      dst_ff <= nxt_dst;
    end
  end

endmodule // qfr_xing
`default_nettype wire

// ==== rtl/qfr_quad_read_top.sv ====
/*
  qfr_quad_read_top: device side of the quad i/o fast read with continuous read mode.
  assumes: host drives spi_sck (mode 0, idle low, stopped while spi_cs_n is high),
  spi_cs_n and the four data lines synchronously to spi_sck; registers over axi4-lite.
*/
// How it works
// - mode byte upper nibble A enters continuous read mode; next frame skips opcode.
// - continuous mode persists for every frame whose mode nibble is again A.
// - any other mode nibble leaves continuous mode; next frame needs a full opcode.
// - device drives data only after the configured dummy clock count.
// - opcode EB takes a 3-byte address while extended addressing is off.
// - EB with extended addressing on, and EC always, take a 4-byte address.
// - mode byte is two clocks after address; only its upper nibble counts.
// - dummy count includes the two mode clocks.
// - opcode is shifted in on data line zero over eight clocks.
// - address, mode and data move four bits per clock.
`timescale 1ns/1ns
`default_nettype none
module qfr_quad_read_top #(
  parameter logic [3:0] DUMMY_RESET = qfr_pkg::DUMMY_RST
) (
  // system
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // quad serial link
  input  wire logic        spi_sck,
  input  wire logic        spi_cs_n,
  input  wire logic [3:0]  io_in,
  output logic [3:0]       io_out,
  output logic [3:0]       io_oe
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic qfr_pkg::qfr_reg_sel_t reg_sel(input logic [7:0] a);
    case (a)
      qfr_pkg::REG_CTRL:   reg_sel = qfr_pkg::SEL_CTRL;
      qfr_pkg::REG_STATUS: reg_sel = qfr_pkg::SEL_STATUS;
      qfr_pkg::REG_ADDR:   reg_sel = qfr_pkg::SEL_ADDR;
      default:             reg_sel = qfr_pkg::SEL_NONE;
    endcase
  endfunction

  // array contents are a seeded pattern of the address; no real storage here
  function automatic logic [7:0] data_of(input logic [31:0] a, input logic [7:0] seed);
    data_of = a[7:0] ^ seed;
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        ext;
    logic [3:0]  dummy;
    logic [7:0]  seed;
    logic        dirty;
    logic        cont;
    logic        wide;
    logic [31:0] last_addr;
    logic        cs_s1;
    logic        cs_s2;
  } qfr_ref_t;

  typedef struct packed {
    qfr_pkg::qfr_link_state_t state;
    logic [3:0]  cnt;
    logic [7:0]  cmd;
    logic [31:0] addr;
    logic        wide;
    logic        ext;
    logic [3:0]  dummy;
    logic [7:0]  seed;
    logic [3:0]  mode_hi;
    logic [7:0]  out_byte;
    logic        nib_lo;
    logic        drive;
  } qfr_frame_t;

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic cont;
    logic cont_ec;
  } qfr_keep_t;

  qfr_ref_t   ref_ff,   nxt_ref;
  qfr_frame_t frame_ff, nxt_frame;
  qfr_keep_t  keep_ff,  nxt_keep;
  logic       mode_done;
  logic       mode_hit;
  logic [3:0] dummy_eff;
  logic [31:0] rd_word;

  qfr_xing_if #(.W(qfr_pkg::CFG_W))  cfg_x ();
  qfr_xing_if #(.W(qfr_pkg::STAT_W)) st_x ();

  qfr_xing #(
    .W       (qfr_pkg::CFG_W),
    .RST_VAL ({qfr_pkg::CTRL_SEED_RST, DUMMY_RESET, qfr_pkg::CTRL_EXT_RST})
  ) u_cfg_xing (
    .src_clk   (ref_clk),
    .src_rst_n (reset_n),
    .dst_clk   (spi_sck),
    .dst_rst_n (keep_ff.rst_s2),
    .x         (cfg_x.xing)
  );

  qfr_xing #(
    .W       (qfr_pkg::STAT_W),
    .RST_VAL ('0)
  ) u_stat_xing (
    .src_clk   (spi_sck),
    .src_rst_n (keep_ff.rst_s2),
    .dst_clk   (ref_clk),
    .dst_rst_n (reset_n),
    .x         (st_x.xing)
  );

  // ----------------------------------------------------------------
  // register side (ref_clk)
  // ----------------------------------------------------------------
  assign s_axi_awready = ~ref_ff.aw_got & ~ref_ff.bvalid;
  assign s_axi_wready  = ~ref_ff.w_got & ~ref_ff.bvalid;
  assign s_axi_arready = ~ref_ff.rvalid;
  assign s_axi_bvalid  = ref_ff.bvalid;
  assign s_axi_bresp   = ref_ff.bresp;
  assign s_axi_rvalid  = ref_ff.rvalid;
  assign s_axi_rdata   = ref_ff.rdata;
  assign s_axi_rresp   = ref_ff.rresp;
  assign cfg_x.load     = ref_ff.dirty;
  assign cfg_x.src_data = {ref_ff.seed, ref_ff.dummy, ref_ff.ext};

  always_comb begin
    nxt_ref       = ref_ff;
    nxt_ref.cs_s1 = spi_cs_n;
    nxt_ref.cs_s2 = ref_ff.cs_s1;
    // a fresh write below sets dirty again, so it is never lost
    if (ref_ff.dirty && !cfg_x.busy) begin
      nxt_ref.dirty = 1'b0;
    end
    if (st_x.dst_valid) begin
      {nxt_ref.cont, nxt_ref.wide, nxt_ref.last_addr} = st_x.dst_data;
    end
    if (ref_ff.bvalid && s_axi_bready) begin
      nxt_ref.bvalid = 1'b0;
    end
    if (s_axi_awvalid && !ref_ff.aw_got) begin
      nxt_ref.aw_got  = 1'b1;
      nxt_ref.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !ref_ff.w_got) begin
      nxt_ref.w_got  = 1'b1;
      nxt_ref.w_data = s_axi_wdata;
      nxt_ref.w_strb = s_axi_wstrb;
    end
    if (ref_ff.aw_got && ref_ff.w_got && !ref_ff.bvalid) begin
      nxt_ref.aw_got = 1'b0;
      nxt_ref.w_got  = 1'b0;
      nxt_ref.bvalid = 1'b1;
      nxt_ref.bresp  = qfr_pkg::RESP_OKAY;
      case (reg_sel(ref_ff.aw_addr))
        qfr_pkg::SEL_CTRL: begin
          if (ref_ff.w_strb[0]) begin
            nxt_ref.ext   = ref_ff.w_data[qfr_pkg::CTRL_EXT_BIT];
            nxt_ref.dummy = ref_ff.w_data[qfr_pkg::CTRL_DUMMY_LSB +: 4];
          end
          if (ref_ff.w_strb[1]) begin
            nxt_ref.seed = ref_ff.w_data[qfr_pkg::CTRL_SEED_LSB +: 8];
          end
          nxt_ref.dirty = 1'b1;
        end
        qfr_pkg::SEL_STATUS, qfr_pkg::SEL_ADDR: begin
          nxt_ref.bresp = qfr_pkg::RESP_OKAY;
        end
        default: begin
          nxt_ref.bresp = qfr_pkg::RESP_SLVERR;
        end
      endcase
    end
    rd_word = '0;
    if (ref_ff.rvalid && s_axi_rready) begin
      nxt_ref.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !ref_ff.rvalid) begin
      nxt_ref.rvalid = 1'b1;
      nxt_ref.rresp  = qfr_pkg::RESP_OKAY;
      case (reg_sel(s_axi_araddr))
        qfr_pkg::SEL_CTRL: begin
          rd_word[qfr_pkg::CTRL_EXT_BIT]         = ref_ff.ext;
          rd_word[qfr_pkg::CTRL_DUMMY_LSB +: 4]  = ref_ff.dummy;
          rd_word[qfr_pkg::CTRL_SEED_LSB +: 8]   = ref_ff.seed;
        end
        qfr_pkg::SEL_STATUS: begin
          rd_word[qfr_pkg::STAT_CONT_BIT]   = ref_ff.cont;
          rd_word[qfr_pkg::STAT_WIDE_BIT]   = ref_ff.wide;
          rd_word[qfr_pkg::STAT_BUSY_BIT]   = ref_ff.dirty | cfg_x.busy;
          rd_word[qfr_pkg::STAT_ACTIVE_BIT] = ~ref_ff.cs_s2;
        end
        qfr_pkg::SEL_ADDR: begin
          rd_word = ref_ff.last_addr;
        end
        default: begin
          nxt_ref.rresp = qfr_pkg::RESP_SLVERR;
        end
      endcase
      nxt_ref.rdata = rd_word;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ref_ff       <= '0;
      ref_ff.ext   <= qfr_pkg::CTRL_EXT_RST;
      ref_ff.dummy <= DUMMY_RESET;
      ref_ff.seed  <= qfr_pkg::CTRL_SEED_RST;
      ref_ff.dirty <= 1'b1;
      ref_ff.cs_s1 <= 1'b1;
      ref_ff.cs_s2 <= 1'b1;
    end else begin
      ref_ff <= nxt_ref;
    end
  end

  // ----------------------------------------------------------------
  // link side (spi_sck)
  // ----------------------------------------------------------------
  // lines are released the moment chip select rises, with no sck edge needed
  assign io_oe  = {4{frame_ff.drive & ~spi_cs_n}};
  assign io_out = io_oe[0] ? (frame_ff.nib_lo ? frame_ff.out_byte[3:0]
                                              : frame_ff.out_byte[7:4]) : 4'h0;
  // the mode clocks cannot be shortened, so a smaller count reads as two
  assign dummy_eff = (frame_ff.dummy < qfr_pkg::MODE_CLKS) ? qfr_pkg::MODE_CLKS
                                                           : frame_ff.dummy;
  assign st_x.load     = mode_done;
  assign st_x.src_data = {mode_hit, frame_ff.wide, frame_ff.addr};

  always_comb begin
    nxt_frame       = frame_ff;
    nxt_keep        = keep_ff;
    nxt_keep.rst_s1 = reset_n;
    nxt_keep.rst_s2 = keep_ff.rst_s1;
    mode_done       = 1'b0;
    mode_hit        = 1'b0;
    case (frame_ff.state)
      qfr_pkg::LK_IDLE: begin
        {nxt_frame.seed, nxt_frame.dummy, nxt_frame.ext} = cfg_x.dst_data;
        if (keep_ff.cont) begin
          // first edge already carries the top address nibble
          nxt_frame.cmd   = keep_ff.cont_ec ? qfr_pkg::OP_QUAD_READ_WIDE
                                            : qfr_pkg::OP_QUAD_READ;
          nxt_frame.wide  = keep_ff.cont_ec | cfg_x.dst_data[0];
          nxt_frame.addr  = {28'h0000000, io_in};
          nxt_frame.cnt   = 4'h1;
          nxt_frame.state = qfr_pkg::LK_ADDR;
        end else begin
          nxt_frame.cmd   = {7'h00, io_in[0]};
          nxt_frame.cnt   = 4'h1;
          nxt_frame.state = qfr_pkg::LK_CMD;
        end
      end
      qfr_pkg::LK_CMD: begin
        nxt_frame.cmd = {frame_ff.cmd[6:0], io_in[0]};
        nxt_frame.cnt = frame_ff.cnt + 4'h1;
        if (frame_ff.cnt == qfr_pkg::CMD_CLKS - 4'h1) begin
          nxt_frame.cnt = 4'h0;
          if (nxt_frame.cmd == qfr_pkg::OP_QUAD_READ) begin
            nxt_frame.wide  = frame_ff.ext;
            nxt_frame.state = qfr_pkg::LK_ADDR;
          end else if (nxt_frame.cmd == qfr_pkg::OP_QUAD_READ_WIDE) begin
            nxt_frame.wide  = 1'b1;
            nxt_frame.state = qfr_pkg::LK_ADDR;
          end else begin
            nxt_frame.state = qfr_pkg::LK_IGNORE;
          end
        end
      end
      qfr_pkg::LK_ADDR: begin
        nxt_frame.addr = {frame_ff.addr[27:0], io_in};
        nxt_frame.cnt  = frame_ff.cnt + 4'h1;
        if (frame_ff.cnt == (frame_ff.wide ? qfr_pkg::WIDE_NIBBLES
                                           : qfr_pkg::NARROW_NIBBLES) - 4'h1) begin
          nxt_frame.cnt   = 4'h0;
          nxt_frame.state = qfr_pkg::LK_MODE;
        end
      end
      qfr_pkg::LK_MODE: begin
        nxt_frame.cnt = frame_ff.cnt + 4'h1;
        if (frame_ff.cnt == 4'h0) begin
          nxt_frame.mode_hi = io_in;
        end
        if (frame_ff.cnt == qfr_pkg::MODE_CLKS - 4'h1) begin
          // low nibble is never looked at, so a floating bus is harmless
          mode_done        = 1'b1;
          mode_hit         = frame_ff.mode_hi == qfr_pkg::MODE_CONT_NIBBLE;
          nxt_keep.cont    = mode_hit;
          nxt_keep.cont_ec = frame_ff.cmd == qfr_pkg::OP_QUAD_READ_WIDE;
          nxt_frame.cnt    = 4'h0;
          if (dummy_eff == qfr_pkg::MODE_CLKS) begin
            nxt_frame.out_byte = data_of(frame_ff.addr, frame_ff.seed);
            nxt_frame.nib_lo   = 1'b0;
            nxt_frame.drive    = 1'b1;
            nxt_frame.state    = qfr_pkg::LK_DATA;
          end else begin
            nxt_frame.state = qfr_pkg::LK_DUMMY;
          end
        end
      end
      qfr_pkg::LK_DUMMY: begin
        nxt_frame.cnt = frame_ff.cnt + 4'h1;
        if (frame_ff.cnt == dummy_eff - qfr_pkg::MODE_CLKS - 4'h1) begin
          nxt_frame.out_byte = data_of(frame_ff.addr, frame_ff.seed);
          nxt_frame.nib_lo   = 1'b0;
          nxt_frame.drive    = 1'b1;
          nxt_frame.state    = qfr_pkg::LK_DATA;
        end
      end
      qfr_pkg::LK_DATA: begin
        if (!frame_ff.nib_lo) begin
          nxt_frame.nib_lo = 1'b1;
        end else begin
          nxt_frame.addr     = frame_ff.addr + 32'h00000001;
          nxt_frame.out_byte = data_of(frame_ff.addr + 32'h00000001, frame_ff.seed);
          nxt_frame.nib_lo   = 1'b0;
        end
      end
      qfr_pkg::LK_IGNORE: begin
        nxt_frame.drive = 1'b0;
      end
      default: begin
        nxt_frame.state = qfr_pkg::LK_IGNORE;
      end
    endcase
    if (!keep_ff.rst_s2) begin
      nxt_keep.cont    = 1'b0;
      nxt_keep.cont_ec = 1'b0;
    end
  end

  // frame state is cleared by chip select itself; sck is still between frames
  always_ff @(posedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      frame_ff <= '0;
    end else begin
      frame_ff <= nxt_frame;
    end
  end

  // mode state survives deselect; the system reset or a mode nibble other than A clears it
  always_ff @(posedge spi_sck) begin
    keep_ff <= nxt_keep;
  end

endmodule // qfr_quad_read_top
`default_nettype wire

// ==== test/qfr_checker.sv ====
/*
  qfr_checker: port assertions for the quad read block.
  assumes: bound to qfr_quad_read_top; spi_sck stops while deselected.
*/
`timescale 1ns/1ns
`default_nettype none
module qfr_checker (
  // system and bus
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // link
  input wire logic        spi_sck,
  input wire logic        spi_cs_n,
  input wire logic [3:0]  io_out,
  input wire logic [3:0]  io_oe
);
  // ----------------------------------------------------------------
  // clocks seen in the current frame
  // ----------------------------------------------------------------
  logic [7:0] cnt_ff;
  always_ff @(posedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      cnt_ff <= 8'h00;
    end else if (cnt_ff != 8'hFF) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end
  a_write_answer: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_aw_blocked: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  a_read_answer: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read response late");
  a_ar_blocked: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_read_holds: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_oe_framed: assert property (@(posedge ref_clk) disable iff (!reset_n)
    spi_cs_n |-> io_oe == 4'h0) else $error("drive while deselected");
  a_oe_lanes: assert property (@(posedge ref_clk) disable iff (!reset_n)
    io_oe == 4'h0 || io_oe == 4'hF) else $error("lanes enabled apart");
  a_out_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
    io_oe == 4'h0 |-> io_out == 4'h0) else $error("output not quiet");
  a_oe_late: assert property (@(posedge spi_sck) disable iff (!reset_n)
    $rose(io_oe[0]) |-> cnt_ff >= 8'h08) else $error("drive before dummy end");
endmodule // qfr_checker
bind qfr_quad_read_top qfr_checker i_chk (.*);
`default_nettype wire

// ==== test/qfr_host_model.sv ====
/*
  qfr_host_model: quad serial host issuing read frames.
  assumes: device updates lines after rising spi_sck; 15 ns link period.
*/
`timescale 1ns/1ns
`default_nettype none
module qfr_host_model (
  // link
  output logic       spi_sck,
  output logic       spi_cs_n,
  output logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe
);
  logic [3:0]  h_oe = 4'h0;
  logic [3:0]  h_dat = 4'h0;
  logic [3:0]  lst = 4'h0;
  logic [15:0] rd_w = 16'h0000;
  logic        oe_ok = 1'b0;
  // undriven lines flip so a stale level never reads as data
  assign io_in = (io_oe & io_out) | (~io_oe & h_oe & h_dat) | (~io_oe & ~h_oe & ~lst);
  always @(posedge spi_sck) lst <= io_in;
  initial begin
    spi_sck = 1'b0;
    spi_cs_n = 1'b1;
  end
  // ----------------------------------------------------------------
  // one link clock; q is sampled just before the rising edge
  // ----------------------------------------------------------------
  task automatic clk(input logic [3:0] e, input logic [3:0] v, output logic [3:0] q);
    h_oe = e;
    h_dat = v;
    #7;
    q = io_out;
    oe_ok &= &io_oe;
    spi_sck = 1'b1;
    #8 spi_sck = 1'b0;
  endtask
  task automatic xfer(input bit c, input logic [7:0] op, input logic [31:0] a,
                      input int na, input logic [7:0] m, input int dm, input int nd);
    logic [3:0] q;
    spi_cs_n = 1'b0;
    #8;
    if (c) for (int i = 7; i >= 0; i--) clk(4'h1, {3'h0, op[i]}, q);
    for (int i = na - 1; i >= 0; i--) clk(4'hF, a[4*i+:4], q);
    clk(4'hF, m[7:4], q);
    clk(dm > 2 ? 4'hF : 4'h0, m[3:0], q);
    for (int i = 2; i < dm; i++) clk(4'h0, 4'h0, q);
    oe_ok = 1'b1;
    for (int i = 0; i < nd; i++) begin
      clk(4'h0, 4'h0, q);
      rd_w = {rd_w[11:0], q};
    end
    #7 spi_cs_n = 1'b1;
    #15;
  endtask
endmodule // qfr_host_model
`default_nettype wire

// ==== test/qfr_quad_read_top_tb.sv ====
/*
  qfr_quad_read_top_tb: register and read-frame scenarios.
  assumes: qfr_host_model drives the link; 20 MHz register clock.
*/
`timescale 1ns/1ns
`default_nettype none
module qfr_quad_read_top_tb;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic        spi_sck, spi_cs_n;
  logic [3:0]  io_in, io_out, io_oe;
  int          bad_count = 0, n_tests = 0, cyc = 0;
  localparam logic [7:0] SD = 8'h5A;
  always #25 ref_clk = ~ref_clk;
  qfr_quad_read_top i_dut (.*);
  qfr_host_model i_host (.*);
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= v;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do @(negedge ref_clk); while (!(s_axi_awready && s_axi_wready));
    @(posedge ref_clk);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid  <= 1'b0;
    do @(negedge ref_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge ref_clk);
    s_axi_bready <= 1'b0;
  endtask
  // late rready: the response must stand
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge ref_clk); while (!s_axi_arready);
    @(posedge ref_clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge ref_clk); while (!s_axi_rvalid);
    @(posedge ref_clk);
    s_axi_rready <= 1'b1;
    @(negedge ref_clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge ref_clk);
    s_axi_rready <= 1'b0;
  endtask
  // config needs link clocks to land
  task automatic cfg(input logic [31:0] v);
    wr(qfr_pkg::REG_CTRL, v);
    repeat (8) begin
      i_host.xfer(1'b1, 8'h00, 32'h0, 0, 8'h00, 2, 0);
      rd(qfr_pkg::REG_STATUS);
      if (!d[qfr_pkg::STAT_BUSY_BIT]) break;
    end
    chk("cfg_busy", 32'(d[qfr_pkg::STAT_BUSY_BIT]), 32'h0);
  endtask
  task automatic fc(input string nm, input bit c, input logic [7:0] op, input logic [31:0] a,
                    input int na, input logic [7:0] m, input int dm);
    i_host.xfer(c, op, a, na, m, dm, 4);
    chk(nm, 32'({i_host.oe_ok, i_host.rd_w}), 32'({1'b1, a[7:0] ^ SD, (a[7:0] + 8'h01) ^ SD}));
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd(qfr_pkg::REG_CTRL);
    chk("ctrl_reset", d, 32'h0000_0060);
    rd(8'h0C);
    chk("unmapped_rresp", 32'(r), 32'(qfr_pkg::RESP_SLVERR));
    chk("unmapped_rdata", d, 32'h0);
    wr(8'h0C, 32'h1);
    chk("unmapped_bresp", 32'(r), 32'(qfr_pkg::RESP_SLVERR));
    wr(qfr_pkg::REG_STATUS, 32'hFFFF_FFFF);
    chk("status_bresp", 32'(r), 32'(qfr_pkg::RESP_OKAY));
    cfg(32'h0000_5A60);
    rd(qfr_pkg::REG_CTRL);
    chk("ctrl_back", d, 32'h0000_5A60);
    $display("test regs done");
  endtask
  task automatic t_cont();
    fc("eb_narrow", 1'b1, 8'hEB, 32'h0000_1230, 6, 8'hA5, 6);
    fc("cont_keep", 1'b0, 8'h00, 32'h0000_40FF, 6, 8'hA0, 6);
    fc("cont_exit", 1'b0, 8'h00, 32'h0000_0033, 6, 8'h5F, 6);
    fc("full_again", 1'b1, 8'hEB, 32'h0000_0044, 6, 8'h00, 6);
    $display("test continuous done");
  endtask
  task automatic t_wide();
    cfg(32'h0000_5A21);
    fc("eb_wide", 1'b1, 8'hEB, 32'h0100_0077, 8, 8'h00, 2);
    cfg(32'h0000_5A20);
    fc("ec_wide", 1'b1, 8'hEC, 32'h0200_0010, 8, 8'hA0, 2);
    fc("ec_cont", 1'b0, 8'h00, 32'h0300_0020, 8, 8'h10, 2);
    fc("eb_short", 1'b1, 8'hEB, 32'h0000_0055, 6, 8'h00, 2);
    $display("test wide done");
  endtask
  task automatic t_abort();
    i_host.xfer(1'b1, 8'hEB, 32'h0000_0066, 6, 8'h00, 2, 1);
    chk("abort_oe", 32'(io_oe), 32'h0);
    i_host.xfer(1'b1, 8'h03, 32'h0000_0066, 6, 8'h00, 2, 4);
    chk("refused", 32'({i_host.oe_ok, i_host.rd_w}), 32'h0);
    fc("after_abort", 1'b1, 8'hEB, 32'h0000_0080, 6, 8'h00, 2);
    $display("test abort done");
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    // link-side mode and crossing state reset only on sck edges
    i_host.xfer(1'b1, 8'h00, 32'h0, 0, 8'h00, 2, 0);
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_regs();
    t_cont();
    t_wide();
    t_abort();
    report_and_stop();
  end
endmodule // qfr_quad_read_top_tb
`default_nettype wire
